/* hdl/eewc_top.sv */
// Purpose: write cache, page commit and acknowledge polling of the EEPROM
// Assumes: prot_hit answers prot_chk_addr in the same cycle
// Notes: read commands are not acknowledged; no read data path here
`timescale 1ns/1ns
module eewc_top #(
    parameter int PAGE_WR_CYCLES = eewc_pkg::PAGE_WR_CYCLES,
    parameter logic [3:0] CTRL_CODE = eewc_pkg::CTRL_CODE_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_pin,
    input wire logic sda_pin_i,
    output logic sda_pin_o,
    output logic sda_pin_oe_n,
    input wire logic chip_sel_bit_zero,
    input wire logic chip_sel_bit_one,
    input wire logic chip_sel_bit_two,
    output logic [eewc_pkg::ADDR_W-1:0] prot_chk_addr,
    input wire logic prot_hit,
    output eewc_pkg::eewc_arr_wr_t arr_wr,
    output logic [eewc_pkg::ADDR_W-1:0] cur_addr,
    output logic [3:0] pages_loaded,
    output logic busy,
    output logic standby
);
    localparam int TMR_W = $clog2(PAGE_WR_CYCLES + 1);
    localparam int WAIT_LOAD = PAGE_WR_CYCLES - eewc_pkg::PAGE_BYTES - 1;

    logic [1:0] bus_s;
    logic [2:0] cs_s;
    logic scl_p_q;
    logic sda_p_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    eewc_pkg::eewc_bus_st_t bs_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [1:0] byte_idx_q;
    logic oe_n_q;
    logic cmd_active_q;
    logic byte_done;
    logic ctrl_match;
    logic ack_now;
    logic wr_begin;
    logic data_take;
    logic commit_go;

    logic [7:0] cache_q [0:eewc_pkg::CACHE_BYTES-1];
    logic [eewc_pkg::CACHE_BYTES-1:0] loaded_q;
    logic [eewc_pkg::CACHE_PAGES-1:0] page_used;
    logic [eewc_pkg::PTR_W-1:0] ld_ptr_q;
    logic [eewc_pkg::ADDR_W-1:0] addr_ptr_q;
    logic [eewc_pkg::PAGE_ADDR_W-1:0] base_page_q;

    eewc_pkg::eewc_cm_st_t cm_q;
    logic [2:0] cm_page_q;
    logic [2:0] cm_byte_q;
    logic [TMR_W-1:0] tmr_q;
    logic [eewc_pkg::PTR_W-1:0] cm_idx;
    logic [eewc_pkg::PAGE_ADDR_W-1:0] cm_arr_page;
    logic cm_last_page;
    eewc_pkg::eewc_arr_wr_t arr_wr_q;

    function automatic logic [3:0] count_pages(
        input logic [eewc_pkg::CACHE_PAGES-1:0] used
    );
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < eewc_pkg::CACHE_PAGES; i++) begin
            n = n + {3'h0, used[i]};
        end
        return n;
    endfunction : count_pages

    eewc_sync #(
        .WIDTH(2),
        .RST_VAL(eewc_pkg::BUS_SYNC_RST)
    ) u_bus_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d({scl_pin, sda_pin_i}),
        .q(bus_s)
    );

    eewc_sync #(
        .WIDTH(3),
        .RST_VAL(eewc_pkg::STRAP_SYNC_RST)
    ) u_strap_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d({chip_sel_bit_two, chip_sel_bit_one, chip_sel_bit_zero}),
        .q(cs_s)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= bus_s[1];
            sda_p_q <= bus_s[0];
        end
    end

    assign scl_rise = bus_s[1] & ~scl_p_q;
    assign scl_fall = ~bus_s[1] & scl_p_q;
    // Data edges while clock high are framing, not data
    assign start_det = bus_s[1] & scl_p_q & sda_p_q & ~bus_s[0];
    assign stop_det = bus_s[1] & scl_p_q & ~sda_p_q & bus_s[0];

    assign busy = (cm_q != eewc_pkg::CM_IDLE);
    assign byte_done = (bs_q == eewc_pkg::BS_RX) && scl_fall
                       && (bit_cnt_q == eewc_pkg::BITS_PER_BYTE);
    // Read requests are refused: this block has no read path
    assign ctrl_match = (shift_q[7:4] == CTRL_CODE)
                        && (shift_q[3:1] == cs_s)
                        && !shift_q[0];
    // Busy hides the device from polling and commands
    assign ack_now = (byte_idx_q == eewc_pkg::IDX_CTRL) ?
                     (ctrl_match && !busy) : 1'b1;
    assign wr_begin = byte_done && ack_now
                      && (byte_idx_q == eewc_pkg::IDX_CTRL);
    assign data_take = byte_done && (byte_idx_q == eewc_pkg::IDX_DATA);
    // Stop ending a write with loaded bytes launches the commit
    assign commit_go = stop_det && cmd_active_q && (|loaded_q);

    // Bus framing and acknowledge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bs_q <= eewc_pkg::BS_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            byte_idx_q <= eewc_pkg::IDX_CTRL;
            oe_n_q <= 1'b1;
        end else if (start_det) begin
            bs_q <= eewc_pkg::BS_RX;
            bit_cnt_q <= 4'h0;
            byte_idx_q <= eewc_pkg::IDX_CTRL;
            oe_n_q <= 1'b1;
        end else if (stop_det) begin
            bs_q <= eewc_pkg::BS_IDLE;
            oe_n_q <= 1'b1;
        end else begin
            case (bs_q)
                eewc_pkg::BS_RX: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], bus_s[0]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        if (ack_now) begin
                            // Pull low after clock fell
                            bs_q <= eewc_pkg::BS_ACK;
                            oe_n_q <= 1'b0;
                        end else begin
                            bs_q <= eewc_pkg::BS_SKIP;
                        end
                    end
                end
                eewc_pkg::BS_ACK: begin
                    if (scl_fall) begin
                        oe_n_q <= 1'b1;
                        bs_q <= eewc_pkg::BS_RX;
                        bit_cnt_q <= 4'h0;
                        if (byte_idx_q != eewc_pkg::IDX_DATA) begin
                            byte_idx_q <= byte_idx_q + 2'h1;
                        end
                    end
                end
                default: begin
                    bs_q <= bs_q;
                end
            endcase
        end
    end

    // A Start without Stop drops the pending command unwritten
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_active_q <= 1'b0;
        end else if (start_det || stop_det) begin
            cmd_active_q <= 1'b0;
        end else if (wr_begin) begin
            cmd_active_q <= 1'b1;
        end
    end

    // Address pointer and cache load position
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_ptr_q <= eewc_pkg::ADDR_RST;
            base_page_q <= eewc_pkg::ADDR_RST[eewc_pkg::ADDR_W-1:3];
            ld_ptr_q <= eewc_pkg::PTR_RST;
        end else if (byte_done && byte_idx_q == eewc_pkg::IDX_ADDR_HI) begin
            // Top three bits of the first address byte are ignored
            addr_ptr_q[12:8] <= shift_q[4:0];
        end else if (byte_done && byte_idx_q == eewc_pkg::IDX_ADDR_LO) begin
            addr_ptr_q[7:0] <= shift_q;
            base_page_q <= {addr_ptr_q[12:8], shift_q[7:3]};
            ld_ptr_q <= {3'h0, shift_q[2:0]};
        end else if (data_take) begin
            addr_ptr_q <= addr_ptr_q + 13'h0001;
            // Six-bit pointer wraps into page 0
            ld_ptr_q <= ld_ptr_q + 6'h01;
        end
    end

    // Cache storage and loaded flags
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loaded_q <= '0;
        end else if (wr_begin) begin
            loaded_q <= '0;
        end else if (data_take) begin
            loaded_q[ld_ptr_q] <= 1'b1;
        end
    end

    // Data storage needs no reset; flags say what is valid
    always_ff @(posedge clk) begin
        if (data_take) begin
            cache_q[ld_ptr_q] <= shift_q;
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < eewc_pkg::CACHE_PAGES; gp++) begin : g_page
            assign page_used[gp] = |loaded_q[gp*8 +: 8];
        end
    endgenerate

    assign pages_loaded = count_pages(page_used);

    assign cm_idx = {cm_page_q, cm_byte_q};
    // Page addition wraps through block boundaries
    assign cm_arr_page = base_page_q + {7'h00, cm_page_q};
    assign prot_chk_addr = {cm_arr_page, cm_byte_q};
    assign cm_last_page = ({1'b0, cm_page_q} + 4'h1) >= pages_loaded;

    // Page commit: eight byte slots then the page wait
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cm_q <= eewc_pkg::CM_IDLE;
            cm_page_q <= 3'h0;
            cm_byte_q <= 3'h0;
            tmr_q <= '0;
        end else begin
            case (cm_q)
                eewc_pkg::CM_IDLE: begin
                    if (commit_go) begin
                        cm_q <= eewc_pkg::CM_BYTES;
                        cm_page_q <= 3'h0;
                        cm_byte_q <= 3'h0;
                    end
                end
                eewc_pkg::CM_BYTES: begin
                    cm_byte_q <= cm_byte_q + 3'h1;
                    if (cm_byte_q == 3'h7) begin
                        cm_q <= eewc_pkg::CM_WAIT;
                        tmr_q <= TMR_W'(WAIT_LOAD);
                    end
                end
                eewc_pkg::CM_WAIT: begin
                    if (tmr_q != '0) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else if (cm_last_page) begin
                        cm_q <= eewc_pkg::CM_IDLE;
                    end else begin
                        cm_page_q <= cm_page_q + 3'h1;
                        cm_q <= eewc_pkg::CM_BYTES;
                    end
                end
                default: begin
                    cm_q <= eewc_pkg::CM_IDLE;
                end
            endcase
        end
    end

    // Array write strobe from flip-flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            arr_wr_q <= '0;
        end else begin
            // Unloaded and protected bytes are skipped silently
            arr_wr_q.en <= (cm_q == eewc_pkg::CM_BYTES)
                           && loaded_q[cm_idx]
                           && !prot_hit;
            arr_wr_q.addr <= prot_chk_addr;
            arr_wr_q.data <= cache_q[cm_idx];
        end
    end

    assign arr_wr = arr_wr_q;
    assign cur_addr = addr_ptr_q;
    assign sda_pin_o = 1'b0;
    assign sda_pin_oe_n = oe_n_q;
    // Unselected or aborted transfers count as standby
    assign standby = !busy && ((bs_q == eewc_pkg::BS_IDLE)
                               || (bs_q == eewc_pkg::BS_SKIP));
endmodule : eewc_top

/* inc/eewc_pkg.sv */
// Purpose: constants and types of the EEPROM write cache block
// Assumes: 100 MHz system clock, two-wire bus sampled as plain inputs
// Notes: cache, page commit and acknowledge polling only; no read path
// Functional notes
// - While committing, never acknowledge a received control byte.
// - A Stop ending a write command starts the timed commit by itself.
// - Acknowledge the polling control byte once commit finished.
// - Cache holds 64 bytes as eight pages of eight bytes.
// - Store data bytes into cache until Stop, then commit.
// - Every loaded page costs one full page cycle, at most 5 ms.
// - Beyond 64 bytes the load pointer wraps to page 0, overwriting.
// - Ignore every bus command while the commit is running.
// - Aligned start writes cached bytes to consecutive addresses, across blocks.
// - First byte goes to cache page 0 at low three address bits.
// - Mid-page start with full cache rolls last bytes into page 0.
// - Cache page 0 goes to start page, later pages to following pages.
// - Only loaded byte positions of a page are written.
// - After Stop and finished commit the block is in standby.
// - Aborted transactions also return the block to standby.
// - Respond only when control byte select bits match the straps.
// - Data line driven open drain only: pull low or release.
// - Data changes only with clock low; changes at high are Start/Stop.
// - Address pointer advances by one after each accessed byte.
// - Protected addresses are silently skipped, others still written.
package eewc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int T_PAGE_WR_MS = 5;
    // Longest time: integer division rounds down
    localparam int PAGE_WR_CYCLES = T_PAGE_WR_MS * (CLK_HZ / 1000);
    localparam int CACHE_PAGES = 8;
    localparam int PAGE_BYTES = 8;
    localparam int CACHE_BYTES = CACHE_PAGES * PAGE_BYTES;
    localparam int ADDR_W = 13;
    localparam int PTR_W = 6;
    localparam int SEL_W = 3;
    localparam int PAGE_ADDR_W = ADDR_W - SEL_W;
    localparam logic [3:0] CTRL_CODE_DEF = 4'hA;
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_ADDR_HI = 2'h1;
    localparam logic [1:0] IDX_ADDR_LO = 2'h2;
    localparam logic [1:0] IDX_DATA = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
    localparam logic [PTR_W-1:0] PTR_RST = 6'h00;
    localparam logic [1:0] BUS_SYNC_RST = 2'h3;
    localparam logic [2:0] STRAP_SYNC_RST = 3'h0;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } eewc_arr_wr_t;

    typedef enum logic [1:0] {
        BS_IDLE,
        BS_RX,
        BS_ACK,
        BS_SKIP
    } eewc_bus_st_t;

    typedef enum logic [1:0] {
        CM_IDLE,
        CM_BYTES,
        CM_WAIT
    } eewc_cm_st_t;
endpackage : eewc_pkg

/* hdl/eewc_sync.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ns
module eewc_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Stage one stays out of the filter: metastability hazard
            q <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
        end
    end
endmodule : eewc_sync

/* bench/eewc_asserts.sv */
// Purpose: port checks of the write cache block
// Assumes: one clock domain, bound to eewc_top
// Notes: counters replace long repetitions
`timescale 1ns/1ns
module eewc_asserts #(
    parameter int PAGE_WR_CYCLES = 40
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_pin,
    input wire logic sda_pin_i,
    input wire logic sda_pin_o,
    input wire logic sda_pin_oe_n,
    input wire logic [12:0] prot_chk_addr,
    input wire logic prot_hit,
    input wire eewc_pkg::eewc_arr_wr_t arr_wr,
    input wire logic [3:0] pages_loaded,
    input wire logic busy,
    input wire logic standby
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    int unsigned busy_cnt_q;
    int unsigned idle_cnt_q;
    logic [3:0] pages_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_cnt_q <= 0;
            pages_q <= 4'h0;
        end else begin
            busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
            pages_q <= busy ? pages_q : pages_loaded;
        end
    end
    // Idle longer than any high data bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            idle_cnt_q <= 0;
        else
            idle_cnt_q <= (scl_pin && sda_pin_i && !busy) ? idle_cnt_q + 1 : 0;
    end
    sequence s_commit_go;
        $rose(busy);
    endsequence
    sequence s_commit_end;
        $fell(busy);
    endsequence
    sda_o_zero_a: assert property (sda_pin_o == 1'b0)
        else $error("data output not zero");
    quiet_busy_a: assert property (busy |-> sda_pin_oe_n)
        else $error("data driven during commit");
    stop_start_a: assert property (s_commit_go |->
        scl_pin && sda_pin_i && pages_loaded != 4'h0)
        else $error("commit began without stop");
    busy_len_a: assert property (s_commit_end |->
        busy_cnt_q == pages_q * PAGE_WR_CYCLES)
        else $error("commit length wrong");
    wr_in_commit_a: assert property (arr_wr.en |-> busy)
        else $error("array write outside commit");
    consec_addr_a: assert property (arr_wr.en && $past(arr_wr.en)
        |-> arr_wr.addr == $past(arr_wr.addr) + 13'h0001)
        else $error("array addresses not consecutive");
    prot_skip_a: assert property (arr_wr.en |->
        arr_wr.addr == $past(prot_chk_addr) && !$past(prot_hit))
        else $error("protected or wrong address written");
    standby_idle_a: assert property (idle_cnt_q > 20
        |-> standby)
        else $error("no standby on idle bus");
    sda_edge_a: assert property ($changed(sda_pin_oe_n)
        |-> !scl_pin)
        else $error("data moved while clock high");
    ack_hold_a: assert property ($fell(sda_pin_oe_n) |->
        !sda_pin_oe_n [*8])
        else $error("acknowledge too short");
endmodule : eewc_asserts

bind eewc_top eewc_asserts #(.PAGE_WR_CYCLES(PAGE_WR_CYCLES)) u_chk (
    .clk, .sys_rst, .scl_pin, .sda_pin_i, .sda_pin_o, .sda_pin_oe_n,
    .prot_chk_addr, .prot_hit, .arr_wr, .pages_loaded, .busy, .standby);

/* bench/eewc_bus_master.sv */
// Purpose: two-wire bus master model
// Assumes: pull-up on data, wire level fed back
// Notes: half period 10 clocks, longer than the pin filter
`timescale 1ns/1ns
module eewc_bus_master (
    input wire logic clk,
    output logic scl,
    output logic sda_oe_n,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
    end
    task automatic hp(input int n);
        repeat (n) @(posedge clk);
    endtask : hp
    task automatic bstart();
        sda_oe_n <= 1'b1;
        // Full low phase: device lets go of its ack only late
        hp(10);
        scl <= 1'b1;
        hp(10);
        sda_oe_n <= 1'b0;
        hp(10);
        scl <= 1'b0;
        hp(2);
    endtask : bstart
    task automatic bstop();
        sda_oe_n <= 1'b0;
        hp(10);
        scl <= 1'b1;
        hp(10);
        sda_oe_n <= 1'b1;
        hp(10);
    endtask : bstop
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_oe_n <= (i == 0) ? 1'b1 : b[i-1]; // Low clock only
            hp(10);
            scl <= 1'b1;
            hp(10);
            if (i == 0)
                ack = ~sda;
            scl <= 1'b0;
            hp(2);
        end
    endtask : wbyte
    task automatic poll(input logic [7:0] c, output int tries);
        logic ack;
        tries = 0;
        do begin
            bstart();
            wbyte(c, ack);
            tries++;
        end while (!ack && tries < 60);
        bstop();
    endtask : poll
endmodule : eewc_bus_master

/* bench/tb_top.sv */
// Purpose: self-checking bench of the write cache block
// Assumes: array and protection map modelled here
// Notes: short page cycle keeps the run brief
`timescale 1ns/1ns
module tb_top;
    localparam int PW = 400;
    localparam logic [12:0] PROT_A = 13'h0105;
    logic clk, sys_rst, scl, m_oe_n, sda, sda_o, oe_n;
    logic prot_on, prot_hit, busy, standby;
    logic [2:0] strap;
    logic [12:0] pchk, cur;
    logic [3:0] pgs;
    eewc_pkg::eewc_arr_wr_t wr;
    logic [7:0] mem [8192];
    logic [7:0] exp_m [8192];
    int bad_count, checked, bcnt;
    assign sda = oe_n & m_oe_n; // Pull-up wire
    assign prot_hit = prot_on && pchk == PROT_A;
    eewc_bus_master m (.clk(clk), .scl(scl), .sda_oe_n(m_oe_n), .sda(sda));
    eewc_top #(.PAGE_WR_CYCLES(PW)) dut (.clk(clk), .sys_rst(sys_rst),
        .scl_pin(scl), .sda_pin_i(sda), .sda_pin_o(sda_o),
        .sda_pin_oe_n(oe_n), .chip_sel_bit_zero(strap[0]),
        .chip_sel_bit_one(strap[1]), .chip_sel_bit_two(strap[2]),
        .prot_chk_addr(pchk), .prot_hit(prot_hit), .arr_wr(wr),
        .cur_addr(cur), .pages_loaded(pgs), .busy(busy),
        .standby(standby));
    always @(posedge clk) begin
        if (wr.en === 1'b1)
            mem[wr.addr] <= wr.data;
        if (busy === 1'b1)
            bcnt <= bcnt + 1;
    end
    task automatic chk(input logic [31:0] g, e, input string s);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t %s got %0h exp %0h", $time, s, g, e);
        end
    endtask : chk
    task automatic cmp_mem();
        int n;
        n = 0;
        for (int i = 0; i < 8192; i++)
            if (mem[i] !== exp_m[i])
                n++;
        chk(n, 0, "array bytes");
    endtask : cmp_mem
    task automatic wr_cmd(input logic [12:0] a, input int n, input bit ab);
        logic ack;
        logic [12:0] t;
        logic [7:0] d;
        int pg, tries;
        m.bstart();
        m.wbyte({eewc_pkg::CTRL_CODE_DEF, strap, 1'b0}, ack);
        chk(ack, 1, "control byte");
        m.wbyte({3'h0, a[12:8]}, ack);
        m.wbyte(a[7:0], ack);
        for (int k = 0; k < n; k++) begin
            d = a[7:0] ^ 8'(k * 5);
            m.wbyte(d, ack);
            t = {a[12:3], 3'h0} + 13'((a[2:0] + k) % 64);
            if (!ab && !(prot_on && t == PROT_A))
                exp_m[t] = d;
        end
        pg = (n == 0 || ab) ? 0 : (a[2:0] + n + 7) / 8;
        pg = (pg > 8) ? 8 : pg;
        bcnt = 0;
        if (ab)
            m.bstart();
        m.bstop();
        if (!ab)
            chk(pgs, pg, "pages loaded");
        m.poll({eewc_pkg::CTRL_CODE_DEF, strap, 1'b0}, tries);
        chk(tries < 60, 1, "poll limit");
        chk(tries > 1, pg > 0, "busy refusals");
        chk(bcnt, pg * PW, "commit length");
        chk(cur, 13'(a + n), "pointer");
        cmp_mem();
        chk(standby, 1, "standby");
    endtask : wr_cmd
    task automatic t_select();
        logic ack;
        m.bstart();
        m.wbyte({eewc_pkg::CTRL_CODE_DEF, 3'h2, 1'b0}, ack);
        chk(ack, 0, "foreign select");
        m.bstart();
        m.wbyte({eewc_pkg::CTRL_CODE_DEF, strap, 1'b1}, ack);
        chk(ack, 0, "read request");
        m.bstop();
        chk(standby, 1, "standby after refusal");
    endtask : t_select
    task automatic t_aligned();
        wr_cmd(13'h01F0, 24, 1'b0);
    endtask : t_aligned
    task automatic t_wrap();
        wr_cmd(13'h1FE2, 66, 1'b0);
    endtask : t_wrap
    task automatic t_prot();
        prot_on <= 1'b1;
        wr_cmd(13'h0103, 5, 1'b0);
        prot_on <= 1'b0;
    endtask : t_prot
    task automatic t_abort();
        wr_cmd(13'h0300, 4, 1'b1);
        wr_cmd(13'h0400, 0, 1'b0);
    endtask : t_abort
    task automatic final_report();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        sys_rst = 1'b1;
        strap = 3'h5;
        prot_on = 1'b0;
        bad_count = 0;
        checked = 0;
        bcnt = 0;
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 8'h5A;
            exp_m[i] = 8'h5A;
        end
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (100) @(posedge clk);
        t_select();
        t_aligned();
        t_wrap();
        t_prot();
        t_abort();
        final_report();
    end
    // Run needs about 0.3 ms; 0.8 ms means a hang
    initial begin
        #800_000;
        bad_count++;
        final_report();
    end
endmodule : tb_top
